// >>> bench/mts_top_monitor.sv
module mts_top_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_we_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   input wire logic wb_ack_o,
   // pins and store
   input wire logic trig_o,
   input wire logic [mts_pkg::NCH-1:0][mts_pkg::DW-1:0] drive_o,
   input wire mts_pkg::mts_setup_t nv_setup_i,
   input wire logic nv_valid_i,
   input wire mts_pkg::mts_setup_t nv_setup_o,
   input wire logic nv_store_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic act;
   logic setw;
   logic chg;
   logic spl_q;
   logic spl_d;
   mts_pkg::mts_setup_t su_q;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   assign act = (trig_o == nv_setup_o.out_rise);
   assign setw = wb_ack_o && wb_we_i && (wb_adr_i == 8'h00 || wb_adr_i == 8'h04);
   // a setup change during a run spoils that run's length
   assign chg = (nv_setup_o != su_q);
   // ---------------------------------
   // active-level run length
   // ---------------------------------
   always_comb begin
      cnt_d = act ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
      spl_d = chg | (act & spl_q);
   end
   always_ff @(posedge clk_i) begin
      cnt_q <= rst_i ? 32'h0000_0000 : cnt_d;
      spl_q <= rst_i ? 1'b0 : spl_d;
      su_q <= nv_setup_o;
   end
   a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_store_after: assert property (setw |=> nv_store_o)
      else $error("setup write not stored");
   a_store_cause: assert property (nv_store_o |-> $past(setw))
      else $error("store without setup write");
   // short runs come from a polarity change, not from a pulse
   a_pulse_width: assert property ((cnt_q > 32'h0000_0002 && !act && !spl_q && !chg) |->
      cnt_q == 32'h0000_0032 * nv_setup_o.width) else $error("pulse width wrong");
   a_setup_load: assert property (($fell(rst_i) && nv_valid_i) |=>
      nv_setup_o == $past(nv_setup_i)) else $error("stored setup not loaded");
   a_setup_dflt: assert property (($fell(rst_i) && !nv_valid_i) |->
      nv_setup_o == mts_pkg::SETUP_RST) else $error("setup default wrong");
   a_idle_reset: assert property ($fell(rst_i) |-> trig_o && drive_o == '0)
      else $error("outputs not idle after reset");
endmodule

bind mts_top mts_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
   .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
   .trig_o(trig_o), .drive_o(drive_o), .nv_setup_i(nv_setup_i), .nv_valid_i(nv_valid_i),
   .nv_setup_o(nv_setup_o), .nv_store_o(nv_store_o));

// >>> bench/mts_trig_rx.sv
module mts_trig_rx (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // trigger line
   input wire logic trig_i,
   input wire logic rise_i,
   // measurement
   output logic [15:0] n_pulse_o,
   output logic [31:0] width_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] run_q;
   // glitches of two cycles or less are not taken as pulses
   always @(posedge clk_i) begin
      if (rst_i) begin
         n_pulse_o <= 16'h0;
         width_o <= 32'h0;
         run_q <= 32'h0;
      end else if (trig_i == rise_i) begin
         run_q <= run_q + 32'h1;
      end else begin
         if (run_q > 32'h2) begin
            n_pulse_o <= n_pulse_o + 16'h1;
            width_o <= run_q;
         end
         run_q <= 32'h0;
      end
   end
endmodule

// >>> bench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, pause_req_i, trig_in_i;
   logic trig_o, nv_valid_i, nv_store_o;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, pw;
   logic [mts_pkg::NCH-1:0][mts_pkg::DW-1:0] drive_o;
   logic [63:0] dp;
   mts_pkg::mts_setup_t nv_mem, nv_setup_o;
   logic [15:0] n_pulse, n0, prev, dlt;
   int n_errors, n_tests, good, hi;
   mts_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'hF), .wb_stb_i(wb_stb_i),
      .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .pause_req_i(pause_req_i),
      .trig_in_i(trig_in_i), .trig_o(trig_o), .drive_o(drive_o), .nv_setup_i(nv_mem),
      .nv_valid_i(nv_valid_i), .nv_setup_o(nv_setup_o), .nv_store_o(nv_store_o));
   mts_trig_rx u_rx (.clk_i(clk_i), .rst_i(rst_i), .trig_i(trig_o),
      .rise_i(nv_setup_o.out_rise), .n_pulse_o(n_pulse), .width_o(pw));
   // nonvolatile store keeps whatever the block asks it to save
   always @(posedge clk_i) if (nv_store_o === 1'b1) nv_mem <= nv_setup_o;
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      int t;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50) n_errors++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, e);
   endtask
   // waits for the active level, then for the pulse to be counted
   task automatic pulse(input logic lvl);
      int t;
      t = 0;
      // after a polarity write the line shows the old idle level for two cycles
      while (trig_o === lvl && t < 1000) begin
         @(posedge clk_i);
         t++;
      end
      while (trig_o !== lvl && t < 1000) begin
         @(posedge clk_i);
         t++;
      end
      if (t >= 1000) n_errors++;
      n0 = n_pulse;
      dp = drive_o;
      while (n_pulse === n0 && t < 2000) begin
         @(posedge clk_i);
         t++;
      end
      if (t >= 2000) n_errors++;
   endtask
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
   initial begin
      rst_i = 1'b1;
      {wb_we_i, wb_stb_i, wb_cyc_i, pause_req_i, nv_valid_i} = '0;
      {wb_adr_i, wb_dat_i} = '0;
      trig_in_i = 1'b1;
      nv_mem = mts_pkg::SETUP_RST;
      cyc(10);
      rst_i <= 1'b0;
      cyc(2);
      chk(trig_o, 1'b1);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h19);
      rd(8'h08, 32'h0);
      rd(8'h60, 32'h0);
      for (int n = 0; n < 4; n++) rd(8'h20 + 8'(16 * n), 32'h1);
      for (int s = 0; s < 3; s++) begin
         wr(8'h50, 32'(s));
         rd(8'h50, 32'(s));
      end
      wr(8'h28, 32'h1000);
      rd(8'h2C, 32'h1000);
      wr(8'h2C, 32'h0800);
      rd(8'h2C, 32'h1000);
      wr(8'h2C, 32'h3000);
      wr(8'h24, 32'h0100_0000);
      good = 0;
      prev = drive_o[0];
      for (int i = 0; i < 8; i++) begin
         cyc(4);
         dlt = (drive_o[0] > prev) ? drive_o[0] - prev : prev - drive_o[0];
         if (dlt >= 16'd254 && dlt <= 16'd258) good++;
         prev = drive_o[0];
      end
      chk(good >= 6, 1'b1);
      cyc(300);
      chk(n_pulse, 16'h0);
      wr(8'h04, 32'h2);
      wr(8'h00, 32'h23);
      pulse(1'b1);
      chk(dp[15:0] >= 16'h3F00, 1'b1);
      chk(pw, 32'd100);
      wr(8'h38, 32'h0800);
      wr(8'h3C, 32'h1000);
      wr(8'h34, 32'h0200_0000);
      wr(8'h00, 32'h51);
      pulse(1'b0);
      pulse(1'b0);
      chk(dp[31:16] <= 16'h0900, 1'b1);
      chk(pw, 32'd100);
      pause_req_i <= 1'b1;
      cyc(8);
      rd(8'h08, 32'h1);
      dp = drive_o;
      n0 = n_pulse;
      cyc(200);
      chk(drive_o, dp);
      chk(n_pulse, n0);
      pause_req_i <= 1'b0;
      cyc(8);
      rd(8'h08, 32'h1);
      pause_req_i <= 1'b1;
      cyc(6);
      chk(drive_o[1] - dp[31:16] + 16'h0180 <= 16'h0300, 1'b1);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h50);
      cyc(120);
      trig_in_i <= 1'b0;
      cyc(6);
      rd(8'h08, 32'h4);
      wr(8'h08, 32'h4);
      rd(8'h08, 32'h0);
      trig_in_i <= 1'b1;
      cyc(6);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h54);
      trig_in_i <= 1'b0;
      cyc(6);
      rd(8'h08, 32'h0);
      trig_in_i <= 1'b1;
      cyc(6);
      rd(8'h08, 32'h4);
      wr(8'h40, 32'h2);
      wr(8'h48, 32'h0100);
      wr(8'h4C, 32'h1000);
      wr(8'h44, 32'h1000_0000);
      cyc(4);
      good = 0;
      hi = 0;
      for (int i = 0; i < 32; i++) begin
         cyc(1);
         if (drive_o[2] >= 16'h10F0) hi++;
         if (drive_o[2] <= 16'h0F10) good++;
      end
      chk(hi + good, 32);
      chk(hi >= 14 && hi <= 18, 1'b1);
      wr(8'h58, 32'h1000);
      wr(8'h5C, 32'h3000);
      wr(8'h54, 32'h0400_0000);
      wr(8'h50, 32'h0);
      cyc(4);
      good = 0;
      hi = 0;
      // one full period: a sine dwells near its peaks longer than a triangle
      for (int i = 0; i < 64; i++) begin
         cyc(1);
         if (drive_o[3] >= 16'h3800) hi++;
         if (drive_o[3] <= 16'h2800) good++;
      end
      chk(hi >= 20 && hi <= 26, 1'b1);
      chk(good >= 20 && good <= 26, 1'b1);
      rst_i <= 1'b1;
      nv_valid_i <= 1'b1;
      cyc(10);
      rst_i <= 1'b0;
      cyc(3);
      rd(8'h00, 32'h54);
      rd(8'h04, 32'h2);
      summarize();
   end
endmodule

// >>> common/mts_pkg.sv
// What this block does
// - pause freezes every channel drive output
// - resume continues from the frozen phase
// - each pause request toggles run and pause
// - triangle ramps linearly at frequency-set rate
// - square alternates between amplitude/offset levels
// - trigger follows one selected channel, 1-4
// - trigger output disabled after reset
// - pulse polarity selectable, falling by default
// - position max/min/zero, min equals zero
// - pulse width in microseconds, default 25
// - max position fires at waveform peak
// - min position fires at waveform lowest point
// - setup kept in nonvolatile store, reloaded
// - input trigger edge selectable, falling default
// - four channels, own shape, triangle default
// - offset never below amplitude
// - parameter changes apply without restart
package mts_pkg;

   // -----------------------------------------------------------
   // sizes and timing
   // -----------------------------------------------------------
   localparam int NCH = 4;
   localparam int DW = 16;
   localparam int PHW = 32;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // -----------------------------------------------------------
   // register map
   // -----------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WIDTH = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CH_BASE = 8'h20;
   localparam logic [7:0] OFS_CH_END = 8'h60;
   localparam logic [3:0] OFS_SHAPE = 4'h0;
   localparam logic [3:0] OFS_INC = 4'h4;
   localparam logic [3:0] OFS_AMP = 4'h8;
   localparam logic [3:0] OFS_OFF = 4'hC;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ORISE_BIT = 1;
   localparam int CTRL_IRISE_BIT = 2;
   localparam int CTRL_POS_LSB = 4;
   localparam int CTRL_SEL_LSB = 6;
   localparam int ST_PAUSED_BIT = 0;
   localparam int ST_ACTIVE_BIT = 1;
   localparam int ST_SEEN_BIT = 2;

   localparam logic [1:0] POS_ZERO = 2'h0;
   localparam logic [1:0] POS_MIN = 2'h1;
   localparam logic [1:0] POS_MAX = 2'h2;
   localparam logic [1:0] SH_SINE = 2'h0;
   localparam logic [1:0] SH_TRI = 2'h1;
   localparam logic [1:0] SH_SQR = 2'h2;
   localparam logic [15:0] PW_DEF_US = 16'h0019;

   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef struct packed {
      logic out_rise;
      logic in_rise;
      logic [1:0] pos;
      logic [1:0] sel;
      logic [15:0] width;
   } mts_setup_t;

   typedef struct packed {
      logic [1:0] shape;
      logic [PHW-1:0] inc;
      logic [DW-1:0] amp;
      logic [DW-1:0] off;
   } mts_chan_t;

   typedef enum logic {ST_RUN, ST_PAUSED} mts_state_t;

   localparam mts_setup_t SETUP_RST = '{out_rise: 1'b0, in_rise: 1'b0, pos: POS_ZERO,
                                         sel: 2'h0, width: PW_DEF_US};
   localparam mts_chan_t CHAN_RST = '{shape: SH_TRI, inc: '0, amp: '0, off: '0};

endpackage

// >>> rtl/mts_top.sv
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
module mts_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic wb_ack_o,
   // pins
   input wire logic pause_req_i,
   input wire logic trig_in_i,
   output logic trig_o,
   output logic [mts_pkg::NCH-1:0][mts_pkg::DW-1:0] drive_o,
   // nonvolatile setup store
   input wire mts_pkg::mts_setup_t nv_setup_i,
   input wire logic nv_valid_i,
   output mts_pkg::mts_setup_t nv_setup_o,
   output logic nv_store_o
);

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic chan_hit(input logic [7:0] a);
      chan_hit = (a >= mts_pkg::OFS_CH_BASE) && (a < mts_pkg::OFS_CH_END);
   endfunction

   function automatic logic [1:0] chan_idx(input logic [7:0] a);
      logic [3:0] t;
      t = a[7:4] - mts_pkg::OFS_CH_BASE[7:4];
      chan_idx = t[1:0];
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      wmerge = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            wmerge[b*8 +: 8] = n[b*8 +: 8];
         end
      end
   endfunction

   // normalised shape value in -32767..32767 from the top phase bits
   function automatic int shape_val(input logic [1:0] sh, input logic [15:0] u);
      int x;
      int y;
      x = int'(u[14:0]);
      case (sh)
         mts_pkg::SH_SINE: begin
            // parabolic half-waves: cheap, no table, peak at quarter phase
            y = (x * (32768 - x)) >>> 13;
            if (y > 32767) begin
               y = 32767;
            end
            shape_val = u[15] ? -y : y;
         end
         mts_pkg::SH_SQR: begin
            shape_val = u[15] ? -32767 : 32767;
         end
         default: begin
            shape_val = u[15] ? (32767 - 2 * x) : (2 * x - 32767);
         end
      endcase
   endfunction

   // phase at which the chosen extremum is reached
   function automatic logic [31:0] ext_phase(input logic [1:0] sh, input logic is_max);
      case (sh)
         mts_pkg::SH_SINE: ext_phase = is_max ? 32'h4000_0000 : 32'hC000_0000;
         mts_pkg::SH_SQR: ext_phase = is_max ? 32'h0000_0000 : 32'h8000_0000;
         default: ext_phase = is_max ? 32'h8000_0000 : 32'h0000_0000;
      endcase
   endfunction

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic en_q, en_d;
   logic load_q, load_d;
   logic store_q, store_d;
   logic seen_q, seen_d;
   mts_pkg::mts_setup_t setup_q, setup_d;
   mts_pkg::mts_chan_t [mts_pkg::NCH-1:0] chan_q, chan_d;
   mts_pkg::mts_state_t st_q, st_d;
   logic [2:0] psync_q, psync_d;
   logic [2:0] tsync_q, tsync_d;
   logic [mts_pkg::NCH-1:0][mts_pkg::PHW-1:0] ph_q, ph_d;
   logic [mts_pkg::NCH-1:0][mts_pkg::DW-1:0] drv_q, drv_d;
   logic act_q, act_d;
   logic trig_q, trig_d;
   logic [15:0] pwc_q, pwc_d;
   logic [5:0] tick_q, tick_d;
   logic [31:0] rd_word;
   logic [31:0] wv;
   logic req, wr, in_edge, launch, paused;

   assign req = wb_cyc_i & wb_stb_i;
   assign wr = req & ack_q & wb_we_i;
   assign paused = (st_q == mts_pkg::ST_PAUSED);

   // -----------------------------------------------------------
   // register read view
   // -----------------------------------------------------------
   always_comb begin
      mts_pkg::mts_chan_t c;
      c = chan_q[chan_idx(wb_adr_i)];
      rd_word = '0;
      if (wb_adr_i == mts_pkg::OFS_CTRL) begin
         rd_word[mts_pkg::CTRL_EN_BIT] = en_q;
         rd_word[mts_pkg::CTRL_ORISE_BIT] = setup_q.out_rise;
         rd_word[mts_pkg::CTRL_IRISE_BIT] = setup_q.in_rise;
         rd_word[mts_pkg::CTRL_POS_LSB +: 2] = setup_q.pos;
         rd_word[mts_pkg::CTRL_SEL_LSB +: 2] = setup_q.sel;
      end else if (wb_adr_i == mts_pkg::OFS_WIDTH) begin
         rd_word[15:0] = setup_q.width;
      end else if (wb_adr_i == mts_pkg::OFS_STATUS) begin
         rd_word[mts_pkg::ST_PAUSED_BIT] = paused;
         rd_word[mts_pkg::ST_ACTIVE_BIT] = act_q;
         rd_word[mts_pkg::ST_SEEN_BIT] = seen_q;
      end else if (chan_hit(wb_adr_i)) begin
         case (wb_adr_i[3:0])
            mts_pkg::OFS_SHAPE: rd_word[1:0] = c.shape;
            mts_pkg::OFS_INC: rd_word = c.inc;
            mts_pkg::OFS_AMP: rd_word[15:0] = c.amp;
            mts_pkg::OFS_OFF: rd_word[15:0] = c.off;
            default: rd_word = '0;
         endcase
      end
   end

   assign wv = wmerge(rd_word, wb_dat_i, wb_sel_i);

   // -----------------------------------------------------------
   // bus and setup registers
   // -----------------------------------------------------------
   always_comb begin
      logic [1:0] k;
      k = chan_idx(wb_adr_i);
      ack_d = req & ~ack_q;
      rdat_d = (req & ~ack_q) ? rd_word : rdat_q;
      en_d = en_q;
      setup_d = setup_q;
      chan_d = chan_q;
      load_d = 1'b0;
      store_d = 1'b0;
      seen_d = seen_q;
      if (load_q && nv_valid_i) begin
         setup_d = nv_setup_i;
      end
      if (wr) begin
         if (wb_adr_i == mts_pkg::OFS_CTRL) begin
            en_d = wv[mts_pkg::CTRL_EN_BIT];
            setup_d.out_rise = wv[mts_pkg::CTRL_ORISE_BIT];
            setup_d.in_rise = wv[mts_pkg::CTRL_IRISE_BIT];
            setup_d.pos = wv[mts_pkg::CTRL_POS_LSB +: 2];
            setup_d.sel = wv[mts_pkg::CTRL_SEL_LSB +: 2];
            store_d = 1'b1;
         end else if (wb_adr_i == mts_pkg::OFS_WIDTH) begin
            setup_d.width = wv[15:0];
            store_d = 1'b1;
         end else if (wb_adr_i == mts_pkg::OFS_STATUS) begin
            if (wv[mts_pkg::ST_SEEN_BIT]) begin
               seen_d = 1'b0;
            end
         end else if (chan_hit(wb_adr_i)) begin
            // writes land in the live set: the accumulator keeps running
            case (wb_adr_i[3:0])
               mts_pkg::OFS_SHAPE: chan_d[k].shape = wv[1:0];
               mts_pkg::OFS_INC: chan_d[k].inc = wv;
               mts_pkg::OFS_AMP: begin
                  chan_d[k].amp = wv[15:0];
                  if (chan_q[k].off < wv[15:0]) begin
                     chan_d[k].off = wv[15:0];
                  end
               end
               mts_pkg::OFS_OFF: begin
                  chan_d[k].off = (wv[15:0] < chan_q[k].amp) ? chan_q[k].amp : wv[15:0];
               end
               default: chan_d[k] = chan_q[k];
            endcase
         end
      end
      // an edge in the clearing cycle still sets the flag
      if (in_edge) begin
         seen_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= '0;
         en_q <= 1'b0;
         setup_q <= mts_pkg::SETUP_RST;
         chan_q <= {mts_pkg::NCH{mts_pkg::CHAN_RST}};
         load_q <= 1'b1;
         store_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         en_q <= en_d;
         setup_q <= setup_d;
         chan_q <= chan_d;
         load_q <= load_d;
         store_q <= store_d;
         seen_q <= seen_d;
      end
   end

   // -----------------------------------------------------------
   // pins, pause and waveform generators
   // -----------------------------------------------------------
   always_comb begin
      logic [31:0] p;
      logic [15:0] u;
      longint v;
      p = '0;
      u = '0;
      v = 0;
      psync_d = {psync_q[1:0], pause_req_i};
      tsync_d = {tsync_q[1:0], trig_in_i};
      in_edge = setup_q.in_rise ? (tsync_q[1] & ~tsync_q[2])
                                : (~tsync_q[1] & tsync_q[2]);
      st_d = st_q;
      if (psync_q[1] & ~psync_q[2]) begin
         case (st_q)
            mts_pkg::ST_RUN: st_d = mts_pkg::ST_PAUSED;
            mts_pkg::ST_PAUSED: st_d = mts_pkg::ST_RUN;
            default: st_d = mts_pkg::ST_RUN;
         endcase
      end
      for (int i = 0; i < mts_pkg::NCH; i++) begin
         // frozen phase and output survive the pause untouched
         ph_d[i] = paused ? ph_q[i] : ph_q[i] + chan_q[i].inc;
         u = ph_q[i][31:16];
         v = longint'(chan_q[i].off) +
             ((longint'(chan_q[i].amp) * shape_val(chan_q[i].shape, u)) >>> 15);
         if (v < 0) begin
            v = 0;
         end else if (v > 65535) begin
            v = 65535;
         end
         drv_d[i] = paused ? drv_q[i] : 16'(v);
      end
      p = ext_phase(chan_q[setup_q.sel].shape, setup_q.pos == mts_pkg::POS_MAX);
      launch = en_q & ~paused & (ph_d[setup_q.sel] != ph_q[setup_q.sel]) &
               ((ph_d[setup_q.sel] - p) < (ph_q[setup_q.sel] - p));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= mts_pkg::ST_RUN;
         // chains keep sampling through reset: a cleared chain would fake an edge
         psync_q <= psync_d;
         tsync_q <= tsync_d;
         ph_q <= '0;
         drv_q <= '0;
      end else begin
         st_q <= st_d;
         psync_q <= psync_d;
         tsync_q <= tsync_d;
         ph_q <= ph_d;
         drv_q <= drv_d;
      end
   end

   // -----------------------------------------------------------
   // output trigger pulse
   // -----------------------------------------------------------
   always_comb begin
      act_d = act_q;
      pwc_d = pwc_q;
      tick_d = tick_q;
      if (!act_q) begin
         // a zero width means no pulse at all
         if (launch && setup_q.width != 16'h0000) begin
            act_d = 1'b1;
            pwc_d = setup_q.width;
            tick_d = '0;
         end
      end else if (tick_q == 6'(mts_pkg::TICK_CYC - 1)) begin
         tick_d = '0;
         pwc_d = pwc_q - 16'h0001;
         if (pwc_q == 16'h0001) begin
            act_d = 1'b0;
         end
      end else begin
         tick_d = tick_q + 6'h01;
      end
      trig_d = setup_q.out_rise ? act_d : ~act_d;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_q <= 1'b0;
         pwc_q <= '0;
         tick_q <= '0;
         trig_q <= 1'b1;
      end else begin
         act_q <= act_d;
         pwc_q <= pwc_d;
         tick_q <= tick_d;
         trig_q <= trig_d;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign trig_o = trig_q;
   assign drive_o = drv_q;
   assign nv_setup_o = setup_q;
   assign nv_store_o = store_q;

endmodule
